// file: core/czcrb_bank.sv
`include "czcrb_cfg.svh"

module czcrb_bank
	import czcrb_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire czcrb_word_t reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output czcrb_word_t      reg_rdata,
	output logic             reg_unmapped,
	// Neighbouring threshold high word
	input  wire czcrb_word_t detect_threshold_high_bits,
	// Current-detect threshold and global filter
	output czcrb_wide_t      detect_threshold,
	output logic [3:0]       dc_removal_setting,
	// Channel zero controls
	output logic [9:0]       channel_zero_phase_delay,
	output logic             channel_zero_dc_removal_off,
	output logic [3:0]       channel_zero_dc_setting,
	output logic             channel_zero_dc_active,
	output czcrb_insel_t     channel_zero_input_select,
	output logic             sel_normal,
	output logic             sel_shorted,
	output logic             sel_test_pos,
	output logic             sel_test_neg,
	// Channel zero calibration
	output czcrb_wide_t      offset_corr,
	output czcrb_wide_t      gain_corr,
	output logic             gain_is_unity,
	output logic             cal_changed
);

	// Offset compare shared by write and read decode
	function automatic logic czcrb_hit(input logic [7:0] addr, input logic [7:0] ofs);
		czcrb_hit = (addr == ofs);
	endfunction : czcrb_hit

	// Address decode
	wire logic hit_thr_low;
	wire logic hit_channel_zero_config;
	wire logic hit_ofs_high;
	wire logic hit_ofs_low;
	wire logic hit_gain_high;
	wire logic hit_gain_low;
	wire logic hit_any;
	assign hit_thr_low   = czcrb_hit(reg_addr, `CZCRB_OFS_THR_LOW);
	assign hit_channel_zero_config   = czcrb_hit(reg_addr, `CZCRB_OFS_CHANNEL_ZERO_CONFIG);
	assign hit_ofs_high  = czcrb_hit(reg_addr, `CZCRB_OFS_OFS_HIGH);
	assign hit_ofs_low   = czcrb_hit(reg_addr, `CZCRB_OFS_OFS_LOW);
	assign hit_gain_high = czcrb_hit(reg_addr, `CZCRB_OFS_GAIN_HIGH);
	assign hit_gain_low  = czcrb_hit(reg_addr, `CZCRB_OFS_GAIN_LOW);
	assign hit_any       = hit_thr_low | hit_channel_zero_config | hit_ofs_high | hit_ofs_low | hit_gain_high | hit_gain_low;

	// Per-word write enables
	wire logic wr_thr_low;
	wire logic wr_channel_zero_config;
	wire logic wr_ofs_high;
	wire logic wr_ofs_low;
	wire logic wr_gain_high;
	wire logic wr_gain_low;
	assign wr_thr_low   = reg_wr & hit_thr_low;
	assign wr_channel_zero_config   = reg_wr & hit_channel_zero_config;
	assign wr_ofs_high  = reg_wr & hit_ofs_high;
	assign wr_ofs_low   = reg_wr & hit_ofs_low;
	assign wr_gain_high = reg_wr & hit_gain_high;
	assign wr_gain_low  = reg_wr & hit_gain_low;

	// Stored words
	czcrb_word_t thr_low_q;
	czcrb_word_t channel_zero_config_q;
	czcrb_word_t ofs_high_q;
	czcrb_word_t ofs_low_q;
	czcrb_word_t gain_high_q;
	czcrb_word_t gain_low_q;

	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_THR_LOW),
		.WRITE_MASK  (`CZCRB_WM_THR_LOW)
	) u_thr_low (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_thr_low),
		.wdata (reg_wdata),
		.q     (thr_low_q)
	);

	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_CHANNEL_ZERO_CONFIG),
		.WRITE_MASK  (`CZCRB_WM_CHANNEL_ZERO_CONFIG)
	) u_channel_zero_config (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_channel_zero_config),
		.wdata (reg_wdata),
		.q     (channel_zero_config_q)
	);

	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_OFS_HIGH),
		.WRITE_MASK  (`CZCRB_WM_OFS_HIGH)
	) u_ofs_high (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_ofs_high),
		.wdata (reg_wdata),
		.q     (ofs_high_q)
	);

	// offset low byte, lower byte fixed zero
	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_OFS_LOW),
		.WRITE_MASK  (`CZCRB_WM_OFS_LOW)
	) u_ofs_low (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_ofs_low),
		.wdata (reg_wdata),
		.q     (ofs_low_q)
	);

	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_GAIN_HIGH),
		.WRITE_MASK  (`CZCRB_WM_GAIN_HIGH)
	) u_gain_high (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_gain_high),
		.wdata (reg_wdata),
		.q     (gain_high_q)
	);

	// gain low byte, lower byte fixed zero
	czcrb_field_reg #(
		.RESET_VALUE (`CZCRB_RST_GAIN_LOW),
		.WRITE_MASK  (`CZCRB_WM_GAIN_LOW)
	) u_gain_low (
		.mclk  (mclk),
		.rst   (rst),
		.wr_en (wr_gain_low),
		.wdata (reg_wdata),
		.q     (gain_low_q)
	);

	// Read selection from stored words
	czcrb_word_t rd_mux;
	assign rd_mux = hit_thr_low   ? thr_low_q   :
	                hit_channel_zero_config   ? channel_zero_config_q   :
	                hit_ofs_high  ? ofs_high_q  :
	                hit_ofs_low   ? ofs_low_q   :
	                hit_gain_high ? gain_high_q :
	                hit_gain_low  ? gain_low_q  : `CZCRB_RD_UNMAPPED;

	// Read data valid only in the cycle after the strobe
	czcrb_word_t next_rdata;
	logic        next_unmapped;
	assign next_rdata    = reg_rd ? rd_mux : `CZCRB_RD_UNMAPPED;
	assign next_unmapped = (reg_rd | reg_wr) & ~hit_any;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata    <= `CZCRB_RD_UNMAPPED;
			reg_unmapped <= 1'b0;
		end else begin
			reg_rdata    <= next_rdata;
			reg_unmapped <= next_unmapped;
		end
	end

	// Field views of the stored words
	wire logic [7:0] thr_low_byte;
	wire logic [3:0] dc_set_field;
	wire logic [9:0] phase_field;
	wire logic       dc_off_field;
	wire logic [1:0] insel_field;
	wire logic [7:0] ofs_low_byte;
	wire logic [7:0] gain_low_byte;
	assign thr_low_byte  = thr_low_q[`CZCRB_LOWBYTE_MSB:`CZCRB_LOWBYTE_LSB];
	assign dc_set_field  = thr_low_q[`CZCRB_DCSET_MSB:`CZCRB_DCSET_LSB];
	assign phase_field   = channel_zero_config_q[`CZCRB_PHASE_MSB:`CZCRB_PHASE_LSB];
	assign dc_off_field  = channel_zero_config_q[`CZCRB_DCOFF_BIT];
	assign insel_field   = channel_zero_config_q[`CZCRB_INSEL_MSB:`CZCRB_INSEL_LSB];
	assign ofs_low_byte  = ofs_low_q[`CZCRB_LOWBYTE_MSB:`CZCRB_LOWBYTE_LSB];
	assign gain_low_byte = gain_low_q[`CZCRB_LOWBYTE_MSB:`CZCRB_LOWBYTE_LSB];

	// threshold joins neighbour high word and low byte
	czcrb_wide_t next_threshold;
	assign next_threshold = {detect_threshold_high_bits, thr_low_byte};

	wire logic [3:0] next_ch0_dc_setting;
	wire logic       next_ch0_dc_active;
	assign next_ch0_dc_active  = ~dc_off_field;
	assign next_ch0_dc_setting = dc_off_field ? 4'h0 : dc_set_field;

	czcrb_insel_t next_insel;
	assign next_insel = czcrb_insel_t'(insel_field);

	// Wide calibration words
	czcrb_wide_t next_offset;
	czcrb_wide_t next_gain;
	assign next_offset = {ofs_high_q, ofs_low_byte};
	assign next_gain   = {gain_high_q, gain_low_byte};

	// Pulse on any calibration word write
	wire logic next_cal_changed;
	assign next_cal_changed = wr_ofs_high | wr_ofs_low | wr_gain_high | wr_gain_low;

	// Threshold and filter outputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			detect_threshold   <= 24'h000000;
			dc_removal_setting <= 4'h0;
		end else begin
			detect_threshold   <= next_threshold;
			dc_removal_setting <= dc_set_field;
		end
	end

	// Channel zero filter and phase outputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			channel_zero_phase_delay    <= 10'h000;
			channel_zero_dc_removal_off <= 1'b0;
			channel_zero_dc_setting     <= 4'h0;
			channel_zero_dc_active      <= 1'b1;
		end else begin
			channel_zero_phase_delay    <= phase_field;
			channel_zero_dc_removal_off <= dc_off_field;
			channel_zero_dc_setting     <= next_ch0_dc_setting;
			channel_zero_dc_active      <= next_ch0_dc_active;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			channel_zero_input_select <= CZCRB_IN_NORMAL;
			sel_normal                <= 1'b1;
			sel_shorted               <= 1'b0;
			sel_test_pos              <= 1'b0;
			sel_test_neg              <= 1'b0;
		end else begin
			channel_zero_input_select <= next_insel;
			sel_normal                <= (next_insel == CZCRB_IN_NORMAL);
			sel_shorted               <= (next_insel == CZCRB_IN_SHORTED);
			sel_test_pos              <= (next_insel == CZCRB_IN_TEST_POS);
			sel_test_neg              <= (next_insel == CZCRB_IN_TEST_NEG);
		end
	end

	// Calibration outputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			offset_corr   <= 24'h000000;
			gain_corr     <= `CZCRB_GAIN_UNITY;
			gain_is_unity <= 1'b1;
			cal_changed   <= 1'b0;
		end else begin
			offset_corr   <= next_offset;
			gain_corr     <= next_gain;
			gain_is_unity <= (next_gain == `CZCRB_GAIN_UNITY);
			cal_changed   <= next_cal_changed;
		end
	end

endmodule : czcrb_bank

// file: core/czcrb_cfg.svh
`ifndef CZCRB_CFG_SVH
`define CZCRB_CFG_SVH

// Register offsets
`define CZCRB_OFS_THR_LOW      8'h08
`define CZCRB_OFS_CHANNEL_ZERO_CONFIG      8'h09
`define CZCRB_OFS_OFS_HIGH     8'h0A
`define CZCRB_OFS_OFS_LOW      8'h0B
`define CZCRB_OFS_GAIN_HIGH    8'h0C
`define CZCRB_OFS_GAIN_LOW     8'h0D

// Reset values
`define CZCRB_RST_THR_LOW      16'h0000
`define CZCRB_RST_CHANNEL_ZERO_CONFIG      16'h0000
`define CZCRB_RST_OFS_HIGH     16'h0000
`define CZCRB_RST_OFS_LOW      16'h0000
`define CZCRB_RST_GAIN_HIGH    16'h8000
`define CZCRB_RST_GAIN_LOW     16'h0000

// Writable bit masks, reserved bits cleared
`define CZCRB_WM_THR_LOW       16'hFF0F
`define CZCRB_WM_CHANNEL_ZERO_CONFIG       16'hFFC7
`define CZCRB_WM_OFS_HIGH      16'hFFFF
`define CZCRB_WM_OFS_LOW       16'hFF00
`define CZCRB_WM_GAIN_HIGH     16'hFFFF
`define CZCRB_WM_GAIN_LOW      16'hFF00

// Field positions
`define CZCRB_LOWBYTE_MSB      15
`define CZCRB_LOWBYTE_LSB      8
`define CZCRB_DCSET_MSB        3
`define CZCRB_DCSET_LSB        0
`define CZCRB_PHASE_MSB        15
`define CZCRB_PHASE_LSB        6
`define CZCRB_DCOFF_BIT        2
`define CZCRB_INSEL_MSB        1
`define CZCRB_INSEL_LSB        0

// Unity gain correction word
`define CZCRB_GAIN_UNITY       24'h800000
// Read data for unmapped offsets
`define CZCRB_RD_UNMAPPED      16'h0000

`endif

// file: core/czcrb_field_reg.sv
// One 16-bit bank word with write mask and fixed reserved bits
module czcrb_field_reg
	import czcrb_pkg::*;
#(
	parameter czcrb_word_t RESET_VALUE = 16'h0000,
	parameter czcrb_word_t WRITE_MASK  = 16'hFFFF
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Write side
	input  wire logic        wr_en,
	input  wire czcrb_word_t wdata,
	// Stored word
	output czcrb_word_t      q
);

	// Masked bits keep their value, reserved bits never leave reset
	czcrb_word_t next_q;
	assign next_q = (q & ~WRITE_MASK) | (wdata & WRITE_MASK);

	// Word storage
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= RESET_VALUE;
		end else if (wr_en) begin
			q <= next_q;
		end
	end

endmodule : czcrb_field_reg

// file: core/czcrb_pkg.sv
package czcrb_pkg;

	// Channel zero input source
	typedef enum logic [1:0] {
		CZCRB_IN_NORMAL   = 2'h0,
		CZCRB_IN_SHORTED  = 2'h1,
		CZCRB_IN_TEST_POS = 2'h2,
		CZCRB_IN_TEST_NEG = 2'h3
	} czcrb_insel_t;

	// One bank word
	typedef logic [15:0] czcrb_word_t;

	// A 24-bit calibration or threshold value
	typedef logic [23:0] czcrb_wide_t;

endpackage : czcrb_pkg

// file: dv/czcrb_chk.sv
// Watches the bank's register port and derived outputs
module czcrb_chk
	import czcrb_pkg::*;
(
	// Clock and reset
	input wire logic         mclk,
	input wire logic         rst,
	// Register port
	input wire logic [7:0]   reg_addr,
	input wire czcrb_word_t  reg_wdata,
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire czcrb_word_t  reg_rdata,
	// Derived outputs
	input wire czcrb_word_t  detect_threshold_high_bits,
	input wire czcrb_wide_t  detect_threshold,
	input wire logic [3:0]   dc_removal_setting,
	input wire logic [9:0]   channel_zero_phase_delay,
	input wire logic         channel_zero_dc_removal_off,
	input wire logic [3:0]   channel_zero_dc_setting,
	input wire logic         channel_zero_dc_active,
	input wire czcrb_insel_t channel_zero_input_select,
	input wire logic         sel_normal,
	input wire logic         sel_shorted,
	input wire logic         sel_test_pos,
	input wire logic         sel_test_neg,
	input wire czcrb_wide_t  offset_corr,
	input wire czcrb_wide_t  gain_corr,
	input wire logic         gain_is_unity
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Reserved read bits
	property p_thr_res; reg_rd && reg_addr == 8'h08 |=> reg_rdata[7:4] == 4'h0; endproperty
	a_thr_res: assert property (p_thr_res) else $error("threshold reserved bits not zero");
	property p_cfg_res; reg_rd && reg_addr == 8'h09 |=> reg_rdata[5:3] == 3'h0; endproperty
	a_cfg_res: assert property (p_cfg_res) else $error("config reserved bits not zero");
	property p_low_res; reg_rd && (reg_addr == 8'h0B || reg_addr == 8'h0D) |=> reg_rdata[7:0] == 8'h00; endproperty
	a_low_res: assert property (p_low_res) else $error("low word reserved byte not zero");
	// Threshold follows neighbour word
	property p_thr_hi; !$past(rst) |-> detect_threshold[23:8] == $past(detect_threshold_high_bits); endproperty
	a_thr_hi: assert property (p_thr_hi) else $error("threshold high part wrong");
	// Filter bypass per channel
	property p_bypass;
		channel_zero_dc_setting == (channel_zero_dc_removal_off ? 4'h0 : dc_removal_setting)
			&& channel_zero_dc_active == !channel_zero_dc_removal_off;
	endproperty
	a_bypass: assert property (p_bypass) else $error("channel zero filter control wrong");
	// One-hot input select
	property p_sel;
		{sel_test_neg, sel_test_pos, sel_shorted, sel_normal} == 4'h1 << channel_zero_input_select;
	endproperty
	a_sel: assert property (p_sel) else $error("input select decode wrong");
	// Field updates after a write
	property p_phase; reg_wr && reg_addr == 8'h09 |=> ##1 channel_zero_phase_delay == $past(reg_wdata[15:6], 2); endproperty
	a_phase: assert property (p_phase) else $error("phase delay not written");
	property p_gain; reg_wr && reg_addr == 8'h0C |=> ##1 gain_corr[23:8] == $past(reg_wdata, 2); endproperty
	a_gain: assert property (p_gain) else $error("gain high not written");
	property p_ofs_lo; reg_wr && reg_addr == 8'h0B |=> ##1 offset_corr[7:0] == $past(reg_wdata[15:8], 2); endproperty
	a_ofs_lo: assert property (p_ofs_lo) else $error("offset low not written");
	property p_unity; gain_is_unity == (gain_corr == 24'h800000); endproperty
	a_unity: assert property (p_unity) else $error("unity flag wrong");

	// Main scenarios
	c_bypass: cover property (channel_zero_dc_removal_off);
	c_neg: cover property (sel_test_neg);
	c_ofs: cover property (reg_wr && reg_addr == 8'h0B);
endmodule : czcrb_chk

// file: dv/tb.sv
module tb
	import czcrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic         mclk, rst, reg_wr, reg_rd, reg_unmapped;
	logic [7:0]   reg_addr;
	czcrb_word_t  reg_wdata, reg_rdata, detect_threshold_high_bits;
	czcrb_wide_t  detect_threshold, offset_corr, gain_corr;
	logic [3:0]   dc_removal_setting, channel_zero_dc_setting;
	logic [9:0]   channel_zero_phase_delay;
	logic         channel_zero_dc_removal_off, channel_zero_dc_active, gain_is_unity, cal_changed;
	czcrb_insel_t channel_zero_input_select;
	logic         sel_normal, sel_shorted, sel_test_pos, sel_test_neg;
	int           errors, num_checks;
	localparam czcrb_word_t RSTV [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
	localparam czcrb_word_t WMSK [6] = '{16'hFF0F, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};

	czcrb_bank czcrb_bank_i (.*);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input czcrb_word_t d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input czcrb_word_t e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(24'(reg_rdata), 24'(e));
		// Unmapped flag only off the bank
		chk(24'(reg_unmapped), 24'(a < 8'h08 || a > 8'h0D));
	endtask : rd

	task automatic t_reset;
		for (int i = 0; i < 6; i++) rd(8'h08 + 8'(i), RSTV[i]);
		chk(gain_corr, 24'h800000);
		chk(24'(gain_is_unity), 24'h1);
		chk(24'(dc_removal_setting), 24'h0);
		$display("Test reset done");
	endtask : t_reset

	task automatic t_resv;
		for (int i = 0; i < 6; i++) wr(8'h08 + 8'(i), 16'hFFFF);
		for (int i = 0; i < 6; i++) rd(8'h08 + 8'(i), WMSK[i]);
		chk(detect_threshold, 24'hA5C3FF);
		chk(offset_corr, 24'hFFFFFF);
		chk(gain_corr, 24'hFFFFFF);
		chk(24'(channel_zero_phase_delay), 24'h3FF);
		chk(24'({channel_zero_dc_setting, channel_zero_dc_active}), 24'h0);
		wr(8'h0B, 16'h0000);
		@(negedge mclk);
		chk(24'(cal_changed), 24'h1);
		for (int i = 0; i < 6; i++) wr(8'h08 + 8'(i), 16'h0000);
		for (int i = 0; i < 6; i++) rd(8'h08 + 8'(i), 16'h0000);
		wr(8'h0C, 16'h8000);
		rd(8'h0C, 16'h8000);
		chk(24'(gain_is_unity), 24'h1);
		$display("Test reserved done");
	endtask : t_resv

	task automatic t_mux;
		wr(8'h08, 16'h5AF3);
		rd(8'h08, 16'h5A03);
		chk(detect_threshold, 24'hA5C35A);
		chk(24'(dc_removal_setting), 24'h3);
		for (int c = 0; c < 4; c++) begin
			wr(8'h09, 16'h8078 | 16'(c));
			rd(8'h09, 16'h8040 | 16'(c));
			chk(24'(channel_zero_input_select), 24'(c));
			chk(24'({sel_test_neg, sel_test_pos, sel_shorted, sel_normal}), 24'h1 << c);
			chk(24'(channel_zero_dc_setting), 24'h3);
			chk(24'(channel_zero_phase_delay), 24'h201);
		end
		wr(8'h09, 16'h0004);
		wr(8'h0E, 16'hFFFF);
		@(negedge mclk);
		chk(24'(cal_changed), 24'h0);
		rd(8'h09, 16'h0004);
		chk(24'({channel_zero_dc_removal_off, channel_zero_dc_setting}), 24'h10);
		rd(8'h0E, 16'h0000);
		rd(8'h07, 16'h0000);
		$display("Test select done");
	endtask : t_mux

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		detect_threshold_high_bits = 16'hA5C3;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_resv();
		t_mux();
		summarize();
	end

	// Watchdog
	initial begin
		repeat (2000) @(posedge mclk);
		errors++;
		summarize();
	end
endmodule : tb

bind czcrb_bank czcrb_chk czcrb_chk_i (.*);
